// [src/ctb_pkg.sv]
// constants and types shared by the core transfer buffer
`default_nettype none
package ctb_pkg;
  localparam int POS_W = 7;
  localparam int CHAR_W = 6;
  localparam int TRACK_W = 5;
  localparam int DIGIT_W = 4;
  localparam int NUM_POS = 100;
  localparam logic [POS_W-1:0] POS_LOW_ORDER = 7'h63;
  localparam logic [POS_W-1:0] POS_HIGH_ORDER = 7'h00;
  localparam logic [POS_W-1:0] COUNT_ALL = 7'h64;
  localparam logic [POS_W-1:0] COUNT_ZERO = 7'h00;
  localparam logic [DIGIT_W:0] DIGIT_BASE = 5'h0A;
  localparam int REV_TIME_MS = 10;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_MS = 1000000;
  localparam int REV_CYCLES_DEF = (REV_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [TRACK_W-1:0] src_track;
    logic [POS_W-1:0] src_pos;
    logic [TRACK_W-1:0] dst_track;
    logic [POS_W-1:0] dst_pos;
    logic [POS_W-1:0] count;
    logic src_buf;
    logic dst_acc;
  } ctb_instr_t;

  typedef struct packed {
    logic en;
    logic [TRACK_W-1:0] track;
    logic [POS_W-1:0] pos;
    logic [CHAR_W-1:0] data;
  } ctb_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_FROM = 2'b10,
    ST_TO = 2'b11
  } ctb_state_t;
endpackage
`default_nettype wire

// [src/ctb_drum_timer.sv]
// drum position generator: slots 99 down to 00 per revolution
`default_nettype none
module ctb_drum_timer #(
  parameter int SLOT_CYCLES = 5000
) (
  input wire logic mclk,
  input wire logic srst,
  output logic [ctb_pkg::POS_W-1:0] slot_pos,
  output logic slot_tick,
  output logic rev_end
);
  import ctb_pkg::*;

  logic [31:0] cyc_reg;
  logic [31:0] cyc_next;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;

  always_comb
  begin
    slot_tick = (cyc_reg == 32'(SLOT_CYCLES - 1));
    cyc_next = slot_tick ? 32'h0 : cyc_reg + 32'h1;
    pos_next = pos_reg;
    if (slot_tick)
    begin
      pos_next = (pos_reg == POS_HIGH_ORDER) ? POS_LOW_ORDER : pos_reg - 7'h01;
    end
    rev_end = slot_tick && (pos_reg == POS_HIGH_ORDER);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cyc_reg <= 32'h0;
      pos_reg <= POS_LOW_ORDER;
    end
    else
    begin
      cyc_reg <= cyc_next;
      pos_reg <= pos_next;
    end
  end

  assign slot_pos = pos_reg;
endmodule
`default_nettype wire

// [src/ctb_digit_add.sv]
// one decimal digit adder for accumulating transfers
`default_nettype none
module ctb_digit_add (
  input wire logic [ctb_pkg::CHAR_W-1:0] addend,
  input wire logic [ctb_pkg::CHAR_W-1:0] augend,
  input wire logic carry_in,
  output logic [ctb_pkg::CHAR_W-1:0] sum,
  output logic carry_out
);
  import ctb_pkg::*;

  logic [DIGIT_W:0] raw;

  always_comb
  begin
    raw = {1'b0, addend[DIGIT_W-1:0]} + {1'b0, augend[DIGIT_W-1:0]} + {4'h0, carry_in};
    carry_out = (raw >= DIGIT_BASE);
    if (carry_out)
    begin
      raw = raw - DIGIT_BASE;
    end
    sum = {augend[CHAR_W-1:DIGIT_W], raw[DIGIT_W-1:0]};
  end
endmodule
`default_nettype wire

// [src/ctb_core.sv]
// core transfer buffer: two-revolution track to track transfer
`default_nettype none
// Summary of operation
// - first revolution reads source into buffer
// - low-order source char to slot 99, downward
// - loading stops at count or position 00
// - unloaded buffer slots keep old characters
// - write revolution directly follows read revolution
// - slot 99 to low-order destination, downward
// - writing stops at count or position 00
// - buffer untouched by the write revolution
// - buffer source replays previous buffer contents
// - buffer source always starts at slot 99
// - accumulator destination adds instead of overwriting
module ctb_core #(
  parameter int REV_CYCLES = ctb_pkg::REV_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire ctb_pkg::ctb_instr_t instr,
  output logic busy,
  output logic done,
  output logic [ctb_pkg::TRACK_W-1:0] rd_track,
  output logic [ctb_pkg::POS_W-1:0] rd_pos,
  input wire logic [ctb_pkg::CHAR_W-1:0] rd_char,
  output ctb_pkg::ctb_wr_t wr
);
  import ctb_pkg::*;

  localparam int SLOT_CYCLES = REV_CYCLES / NUM_POS;
  localparam logic [POS_W-1:0] POS_STEP = 7'h01;

  ctb_state_t state_reg;
  ctb_state_t state_next;
  ctb_instr_t instr_reg;
  ctb_instr_t instr_next;
  logic [POS_W-1:0] remain_reg;
  logic [POS_W-1:0] remain_next;
  logic [POS_W-1:0] bidx_reg;
  logic [POS_W-1:0] bidx_next;
  logic started_reg;
  logic started_next;
  logic carry_reg;
  logic carry_next;
  logic done_reg;
  logic done_next;
  logic [TRACK_W-1:0] track_reg;
  logic [TRACK_W-1:0] track_next;
  ctb_wr_t wr_reg;
  ctb_wr_t wr_next;

  logic [CHAR_W-1:0] buf_mem [NUM_POS];
  logic buf_we;
  logic [CHAR_W-1:0] buf_out;

  logic [POS_W-1:0] slot_pos;
  logic slot_tick;
  logic rev_end;
  logic [CHAR_W-1:0] add_sum;
  logic add_carry;
  logic field_on;
  logic from_enter;
  logic to_enter;
  logic xfer_end;
  logic load_go;
  logic emit_go;

  function automatic logic [POS_W-1:0] load_count(input logic [POS_W-1:0] cnt);
    load_count = (cnt == COUNT_ZERO) ? COUNT_ALL : cnt;
  endfunction

  function automatic logic [POS_W-1:0] step_down(input logic [POS_W-1:0] pos);
    step_down = pos - POS_STEP;
  endfunction

  function automatic logic in_field(
    input logic started,
    input logic [POS_W-1:0] slot,
    input logic [POS_W-1:0] first,
    input logic [POS_W-1:0] left
  );
    in_field = (started || slot == first) && left != COUNT_ZERO;
  endfunction

  ctb_drum_timer #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .srst(srst),
    .slot_pos(slot_pos),
    .slot_tick(slot_tick),
    .rev_end(rev_end)
  );

  assign buf_out = buf_mem[bidx_reg];

  ctb_digit_add u_add (
    .addend(buf_out),
    .augend(rd_char),
    .carry_in(carry_reg),
    .sum(add_sum),
    .carry_out(add_carry)
  );

  // phase strobes shared by the state groups
  always_comb
  begin
    from_enter = (state_reg == ST_WAIT) && rev_end;
    to_enter = (state_reg == ST_FROM) && rev_end;
    xfer_end = (state_reg == ST_TO) && rev_end;
    field_on = 1'b0;
    if (state_reg == ST_FROM)
    begin
      field_on = in_field(started_reg, slot_pos, instr_reg.src_pos, remain_reg);
    end
    else if (state_reg == ST_TO)
    begin
      field_on = in_field(started_reg, slot_pos, instr_reg.dst_pos, remain_reg);
    end
    load_go = (state_reg == ST_FROM) && slot_tick && field_on && !instr_reg.src_buf;
    emit_go = (state_reg == ST_TO) && slot_tick && field_on;
  end

  assign buf_we = load_go;

  // sequencer: wait for the drum boundary, then one read and one write revolution
  always_comb
  begin
    state_next = state_reg;
    instr_next = instr_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (start)
        begin
          instr_next = instr;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (from_enter)
        begin
          state_next = ST_FROM;
        end
      end
      ST_FROM:
      begin
        // position 00 is the last slot, so the loading ends with the revolution
        if (to_enter)
        begin
          state_next = ST_TO;
        end
      end
      ST_TO:
      begin
        // the receiving position 00 slot closes the revolution
        if (xfer_end)
        begin
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      instr_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      done_reg <= done_next;
    end
  end

  // track select: source while waiting and reading, destination while writing
  always_comb
  begin
    track_next = track_reg;
    if ((state_reg == ST_IDLE) && start)
    begin
      track_next = instr.src_track;
    end
    else if (to_enter)
    begin
      track_next = instr_reg.dst_track;
    end
    else if (xfer_end)
    begin
      track_next = instr_reg.src_track;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      track_reg <= '0;
    end
    else
    begin
      track_reg <= track_next;
    end
  end

  // field counters: characters left, buffer slot, field started
  always_comb
  begin
    remain_next = remain_reg;
    bidx_next = bidx_reg;
    started_next = started_reg;
    if (load_go || emit_go)
    begin
      started_next = 1'b1;
      bidx_next = step_down(bidx_reg);
      remain_next = step_down(remain_reg);
    end
    if (from_enter || to_enter)
    begin
      remain_next = load_count(instr_reg.count);
      bidx_next = POS_LOW_ORDER;
      started_next = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      remain_reg <= COUNT_ZERO;
      bidx_reg <= POS_LOW_ORDER;
      started_reg <= 1'b0;
    end
    else
    begin
      remain_reg <= remain_next;
      bidx_reg <= bidx_next;
      started_reg <= started_next;
    end
  end

  // write port: copy or accumulate one character per slot
  always_comb
  begin
    wr_next = wr_reg;
    wr_next.en = 1'b0;
    carry_next = carry_reg;
    if (to_enter)
    begin
      carry_next = 1'b0;
    end
    if (emit_go)
    begin
      wr_next.en = 1'b1;
      wr_next.track = instr_reg.dst_track;
      wr_next.pos = slot_pos;
      if (instr_reg.dst_acc)
      begin
        wr_next.data = add_sum;
        carry_next = add_carry;
      end
      else
      begin
        wr_next.data = buf_out;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_reg <= '0;
      carry_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      carry_reg <= carry_next;
    end
  end

  // buffer store is never cleared, slots not written keep their data
  always_ff @(posedge mclk)
  begin
    if (buf_we)
    begin
      buf_mem[bidx_reg] <= rd_char;
    end
  end

  assign busy = (state_reg != ST_IDLE);
  assign done = done_reg;
  assign rd_track = track_reg;
  assign rd_pos = slot_pos;
  assign wr = wr_reg;
endmodule
`default_nettype wire

// [verif/ctb_checker_assertions.sv]
// port checks for the core transfer buffer
`default_nettype none
module ctb_checker #(
  parameter int REV_CYCLES = 1000
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire ctb_pkg::ctb_instr_t instr,
  input wire logic busy,
  input wire logic done,
  input wire logic [ctb_pkg::TRACK_W-1:0] rd_track,
  input wire logic [ctb_pkg::POS_W-1:0] rd_pos,
  input wire logic [ctb_pkg::CHAR_W-1:0] rd_char,
  input wire ctb_pkg::ctb_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ps;
  import ctb_pkg::*;
  localparam int LO = 2 * REV_CYCLES - 2;
  localparam int HI = 3 * REV_CYCLES + 2;
  int cnt_reg;
  int cnt_next;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  always_comb
  begin
    cnt_next = busy ? cnt_reg + 1 : 0;
  end
  always_ff @(posedge mclk)
  begin
    cnt_reg <= srst ? 0 : cnt_next;
  end
  a_busy_rise: assert property (start && !busy |=> busy)
    else $error("busy not raised");
  a_done_idle: assert property (done |-> !busy)
    else $error("busy during done");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_done_time: assert property (done |-> cnt_reg >= LO)
    else $error("transfer too short");
  a_busy_bound: assert property (cnt_reg <= HI)
    else $error("transfer too long");
  a_pos_range: assert property (rd_pos <= 7'h63)
    else $error("position out of range");
  a_pos_step: assert property ($changed(rd_pos) |->
    rd_pos == (($past(rd_pos) == 7'h00) ? 7'h63 : $past(rd_pos) - 7'h01))
    else $error("position order wrong");
  a_pos_hold: assert property ($changed(rd_pos) |=> $stable(rd_pos) [*8])
    else $error("slot too short");
  a_wr_idle: assert property (!busy && !done |-> !wr.en)
    else $error("write while idle");
  a_wr_pulse: assert property (wr.en |=> !wr.en)
    else $error("write strobe too long");
  cover property (done);
  cover property (wr.en);
  cover property (start && busy);
endmodule
`default_nettype wire

// [verif/ctb_drum_model.sv]
// drum track store answering reads and taking writes
`default_nettype none
module ctb_drum_model (
  input wire logic mclk,
  input wire logic [ctb_pkg::TRACK_W-1:0] rd_track,
  input wire logic [ctb_pkg::POS_W-1:0] rd_pos,
  output logic [ctb_pkg::CHAR_W-1:0] rd_char,
  input wire ctb_pkg::ctb_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ps;
  import ctb_pkg::*;
  logic [CHAR_W-1:0] mem [32][NUM_POS];
  always @(posedge mclk)
  begin
    rd_char <= mem[rd_track][rd_pos];
    if (wr.en)
      mem[wr.track][wr.pos] <= wr.data;
  end
endmodule
`default_nettype wire

// [verif/test_core_transfer_buffer.sv]
// bench for the core transfer buffer
`default_nettype none
module test_core_transfer_buffer;
  timeunit 1ns;
  timeprecision 1ps;
  import ctb_pkg::*;
  localparam int REV = 1000;
  logic mclk = 0;
  logic srst = 1;
  logic start = 0;
  ctb_instr_t instr = '0;
  logic busy;
  logic done;
  logic [TRACK_W-1:0] rd_track;
  logic [POS_W-1:0] rd_pos;
  logic [CHAR_W-1:0] rd_char;
  ctb_wr_t wr;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  ctb_core #(.REV_CYCLES(REV)) i_dut (.mclk(mclk), .srst(srst), .start(start),
    .instr(instr), .busy(busy), .done(done), .rd_track(rd_track),
    .rd_pos(rd_pos), .rd_char(rd_char), .wr(wr));
  ctb_drum_model i_mem (.mclk(mclk), .rd_track(rd_track), .rd_pos(rd_pos),
    .rd_char(rd_char), .wr(wr));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  function automatic logic [5:0] f(input int t, input int p);
    return 6'(t * 7 + p);
  endfunction
  task automatic check(input logic [CHAR_W-1:0] seen, input logic [CHAR_W-1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [4:0] st, logic [6:0] sp, logic [4:0] dt,
    logic [6:0] dp, n, logic sb, da);
    int i = 0;
    @(posedge mclk);
    instr <= '{st, sp, dt, dp, n, sb, da};
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    check(busy, 1'b1);
    while (done !== 1'b1 && i < 3100)
    begin
      @(negedge mclk);
      i++;
    end
    check(busy, 1'b0);
    @(negedge mclk);
  endtask
  task automatic t_copy();
    run(5'h01, 7'h63, 5'h02, 7'h63, 7'h00, 1'b0, 1'b0);
    for (int p = 0; p < 100; p++)
      check(i_mem.mem[2][p], f(1, p));
    $display("copy test over");
  endtask
  task automatic t_short();
    run(5'h03, 7'h04, 5'h04, 7'h0B, 7'h08, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++)
      check(i_mem.mem[4][11 - k], k < 5 ? f(3, 4 - k) : f(1, 99 - k));
    check(i_mem.mem[4][12], f(4, 12));
    check(i_mem.mem[4][3], f(4, 3));
    $display("short field test over");
  endtask
  task automatic t_acc();
    i_mem.mem[6][5] = 6'h09;
    i_mem.mem[6][4] = 6'h02;
    i_mem.mem[7][1] = 6'h03;
    i_mem.mem[7][0] = 6'h04;
    run(5'h06, 7'h05, 5'h07, 7'h01, 7'h02, 1'b0, 1'b1);
    check(i_mem.mem[7][1], 6'h02);
    check(i_mem.mem[7][0], 6'h07);
    $display("accumulate test over");
  endtask
  task automatic t_bufsrc();
    run(5'h00, 7'h20, 5'h05, 7'h32, 7'h03, 1'b1, 1'b0);
    check(i_mem.mem[5][50], 6'h09);
    check(i_mem.mem[5][49], 6'h02);
    check(i_mem.mem[5][48], f(3, 2));
    check(i_mem.mem[5][47], f(5, 47));
    $display("buffer source test over");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    for (int t = 0; t < 8; t++)
      for (int p = 0; p < 100; p++)
        i_mem.mem[t][p] = f(t, p);
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    t_copy();
    t_short();
    t_acc();
    t_bufsrc();
    print_verdict();
  end
endmodule
bind ctb_core ctb_checker #(.REV_CYCLES(REV_CYCLES)) i_chk (.mclk(mclk), .srst(srst),
  .start(start), .instr(instr), .busy(busy), .done(done), .rd_track(rd_track),
  .rd_pos(rd_pos), .rd_char(rd_char), .wr(wr));
`default_nettype wire
